// File: flash_status_cfg.svh
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// Instruction codes that drive the paused flag
`define OPC_SUSPEND         8'h75
`define OPC_RESUME          8'h7A

// Status register one bit positions
`define SR1_RANGE_LSB       2
`define SR1_RANGE_MSB       4
`define SR1_TOP_BOTTOM      5
`define SR1_SMALL_UNIT      6
`define SR1_WRITABLE_MASK   8'h7C
`define SR1_RESET           8'h00

// Status register two bit positions
`define SR2_QUAD            1
`define SR2_LOCK_LSB        3
`define SR2_LOCK_MSB        5
`define SR2_INVERT          6
`define SR2_PAUSED          7
`define SR2_RESET           8'h00

// Status register three bit positions
`define SR3_SCHEME          2
`define SR3_DRIVE_LSB       5
`define SR3_DRIVE_MSB       6
`define SR3_RESET           8'h60

// Array geometry, 21-bit byte address, 22-bit arithmetic
`define ARRAY_TOP           22'h1FFFFF
`define ARRAY_END           22'h200000
`define BLOCK_BYTES         22'h010000
`define SECTOR_BYTES        22'h001000
`define HALF_BLOCK_BYTES    22'h008000
`define PAGE_BYTES          22'h000100
`define BLOCK_SHIFT         16
`define SECTOR_SHIFT        12
`define LAST_BLOCK          5'h1F
`define SECTOR_LOCKS        32
`define BLOCK_LOCKS         32

// Drive strength in percent
`define DRIVE_FULL          7'd100
`define DRIVE_THREE_Q       7'd75
`define DRIVE_HALF          7'd50
`define DRIVE_QUARTER       7'd25

`endif

// File: flash_status_pkg.sv
package flash_status_pkg;

    typedef enum logic [2:0]
    {
        CMD_PAGE     = 3'h0,
        CMD_SECTOR   = 3'h1,
        CMD_HALF_BLK = 3'h2,
        CMD_BLOCK    = 3'h3,
        CMD_CHIP     = 3'h4
    } cmd_size_t;

    typedef logic [21:0] span_addr_t;

endpackage

// File: protect_decode_if.sv
`timescale 1ns/1ps
interface protect_decode_if;
    logic                           invert;
    logic                           small_unit;
    logic                           top_bottom;
    logic [2:0]                     range;
    flash_status_pkg::span_addr_t   lo;
    flash_status_pkg::span_addr_t   hi;
    logic                           hit;

    modport requester
    (
        output invert,
        output small_unit,
        output top_bottom,
        output range,
        output lo,
        output hi,
        input  hit
    );

    modport decoder
    (
        input  invert,
        input  small_unit,
        input  top_bottom,
        input  range,
        input  lo,
        input  hi,
        output hit
    );
endinterface

// File: protect_range_decoder.sv
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module protect_range_decoder
(
    protect_decode_if.decoder   dec
);
    flash_status_pkg::span_addr_t   size;
    flash_status_pkg::span_addr_t   plo;
    flash_status_pkg::span_addr_t   phi;
    logic                           none;
    logic                           overlap;

    always_comb
    begin
        size = '0;
        none = 1'b0;
        if (dec.range[2:1] == 2'b11)
        begin
            size = `ARRAY_END;                                             // [RL14]
        end
        else if (dec.range == 3'h0)
        begin
            none = 1'b1;                                                   // [RL12]
        end
        else if (!dec.small_unit)
        begin
            size = `BLOCK_BYTES << (dec.range - 3'h1);                     // [RL12]
        end
        else if (dec.range[2])
        begin
            size = `HALF_BLOCK_BYTES;                                      // [RL13]
        end
        else
        begin
            size = `SECTOR_BYTES << (dec.range - 3'h1);                    // [RL13]
        end
        // Top when clear, bottom when set
        if (dec.top_bottom)
        begin
            plo = '0;                                                      // [RL15]
            phi = size - 22'h1;
        end
        else
        begin
            plo = `ARRAY_END - size;                                       // [RL15]
            phi = `ARRAY_TOP;
        end
    end

    // Whole command extent is compared, not just its start
    always_comb
    begin
        overlap = !none && (dec.hi >= plo) && (dec.lo <= phi);             // [RL20]
        if (dec.invert)
        begin
            dec.hit = none || (dec.lo < plo) || (dec.hi > phi);            // [RL16]
        end
        else
        begin
            dec.hit = overlap;                                             // [RL7]
        end
    end
endmodule

// File: flash_status_protect_decode.sv
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
// Overview of operation
// [RL1] Paused flag at S15 sets after suspend instruction 75h executes; read-only.
// [RL2] Paused flag clears on resume instruction 7Ah or a power cycle; a suspend 75h in the same cycle as a power cycle sets it instead.
// [RL3] Three OTP security-area lock bits at S13..S11, reset to unlocked.
// [RL4] Each lock bit sets alone by write; once set never clears.
// [RL5] Quad enable at S9; while 0 write-guard and pause pins work.
// [RL6] Quad enable 1 turns those pins into IO2/IO3, disables both functions.
// [RL7] Scheme select 0: protection from invert, small-unit, top/bottom, range fields.
// [RL8] Scheme select 1: protection from individual block and sector lock bits.
// [RL9] All individual lock bits become 1 at power-on and any reset.
// [RL10] Drive strength code 00/01/10/11 means 100/75/50/25 percent, default 11.
// [RL11] Reserved bits read as zero and writes to them have no effect.
// [RL12] Blocks: range 001..101 protect 64KB..1MB, 000 protects nothing.
// [RL13] Sectors: range 001,010,011,10x protect 4/8/16/32KB, top or bottom.
// [RL14] Range 11x protects the whole 2MB array.
// [RL15] Top/bottom select 0 places region at top, 1 at bottom.
// [RL16] Invert set protects exactly the complement of the selected region.
// [RL17] Erase or program touching any protected address is ignored.
// [RL18] Under lock scheme, commands aimed at a locked unit are ignored.
// [RL19] Decoding is combinational from current fields and command address.
// [RL20] The full erase extent is compared against the protected region.
module flash_status_protect_decode
(
    input  wire logic                       clk_sys,
    input  wire logic                       arst_n,
    input  wire logic                       power_cycle,
    input  wire logic                       exec_valid,
    input  wire logic [7:0]                 exec_opcode,
    input  wire logic                       wr_one,
    input  wire logic                       wr_two,
    input  wire logic                       wr_three,
    input  wire logic [7:0]                 wr_data,
    input  wire logic                       lock_set,
    input  wire logic                       lock_clear,
    input  wire logic [20:0]                lock_addr,
    input  wire logic                       cmd_valid,
    input  wire logic [20:0]                cmd_addr,
    input  wire flash_status_pkg::cmd_size_t cmd_size,
    output logic [7:0]                      status_config_one,
    output logic [7:0]                      status_config_two,
    output logic [7:0]                      status_config_three,
    output logic                            write_guard_active,
    output logic                            pause_pin_active,
    output logic                            quad_io_active,
    output logic [6:0]                      drive_percent,
    output logic                            cmd_done,
    output logic                            cmd_allowed
);
    logic [4:0]                     range_fields;
    logic                           paused_op_flag;
    logic                           invert_protect;
    logic [2:0]                     otp_area_locks;
    logic                           quad_enable;
    logic                           protect_scheme_select;
    logic [1:0]                     output_strength;
    logic [`BLOCK_LOCKS-1:0]        block_locks;
    logic [`SECTOR_LOCKS-1:0]       sector_locks;
    flash_status_pkg::span_addr_t   cmd_lo;
    flash_status_pkg::span_addr_t   cmd_hi;
    logic                           lock_hit;
    logic                           next_allowed;

    protect_decode_if pd ();

    function automatic logic [6:0] drive_decode(input logic [1:0] code);
        unique case (code)
            2'b00:   drive_decode = `DRIVE_FULL;
            2'b01:   drive_decode = `DRIVE_THREE_Q;
            2'b10:   drive_decode = `DRIVE_HALF;
            2'b11:   drive_decode = `DRIVE_QUARTER;
        endcase
    endfunction

    function automatic flash_status_pkg::span_addr_t extent(input flash_status_pkg::cmd_size_t sz);
        unique case (sz)
            flash_status_pkg::CMD_PAGE:     extent = `PAGE_BYTES;
            flash_status_pkg::CMD_SECTOR:   extent = `SECTOR_BYTES;
            flash_status_pkg::CMD_HALF_BLK: extent = `HALF_BLOCK_BYTES;
            flash_status_pkg::CMD_BLOCK:    extent = `BLOCK_BYTES;
            default:                        extent = `ARRAY_END;
        endcase
    endfunction

    // Range fields: protect_range, top/bottom, small-unit
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            range_fields <= 5'(`SR1_RESET >> `SR1_RANGE_LSB);
        else if (wr_one)
            range_fields <= wr_data[`SR1_SMALL_UNIT:`SR1_RANGE_LSB];       // [RL11]
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            paused_op_flag <= 1'b0;
        else if (exec_valid && exec_opcode == `OPC_SUSPEND)
            paused_op_flag <= 1'b1;                                        // [RL1]
        else if (power_cycle || (exec_valid && exec_opcode == `OPC_RESUME))
            paused_op_flag <= 1'b0;                                        // [RL2]
    end

    // Lock bits only accumulate; only arst_n clears them
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            otp_area_locks <= 3'h0;                                        // [RL3]
        else if (wr_two)
            otp_area_locks <= otp_area_locks | wr_data[`SR2_LOCK_MSB:`SR2_LOCK_LSB]; // [RL4]
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            invert_protect <= 1'b0;
            quad_enable    <= 1'b0;
        end
        else if (wr_two)
        begin
            invert_protect <= wr_data[`SR2_INVERT];
            quad_enable    <= wr_data[`SR2_QUAD];                          // [RL5]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            protect_scheme_select <= 1'(`SR3_RESET >> `SR3_SCHEME);
            output_strength       <= 2'(`SR3_RESET >> `SR3_DRIVE_LSB);     // [RL10]
        end
        else if (wr_three)
        begin
            protect_scheme_select <= wr_data[`SR3_SCHEME];
            output_strength       <= wr_data[`SR3_DRIVE_MSB:`SR3_DRIVE_LSB];
        end
    end

    // Individual locks; a power cycle re-arms them as a reset does
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            block_locks  <= '1;                                            // [RL9]
            sector_locks <= '1;
        end
        else if (power_cycle)
        begin
            block_locks  <= '1;                                            // [RL9]
            sector_locks <= '1;
        end
        else if (lock_set || lock_clear)
        begin
            if (lock_addr[20:16] == 5'h0 || lock_addr[20:16] == `LAST_BLOCK)
                sector_locks[{lock_addr[20], lock_addr[15:12]}] <= lock_set;
            else
                block_locks[lock_addr[20:16]] <= lock_set;
        end
    end

    // Command extent is aligned down to its own size
    always_comb
    begin
        cmd_lo = {1'b0, cmd_addr} & ~(extent(cmd_size) - 22'h1);
        cmd_hi = cmd_lo + extent(cmd_size) - 22'h1;                        // [RL20]
    end

    assign pd.invert     = invert_protect;
    assign pd.small_unit = range_fields[4];
    assign pd.top_bottom = range_fields[3];
    assign pd.range      = range_fields[2:0];
    assign pd.lo         = cmd_lo;
    assign pd.hi         = cmd_hi;

    protect_range_decoder u_range
    (
        .dec (pd.decoder)
    );

    // Any locked unit that overlaps the extent blocks the command
    always_comb
    begin
        lock_hit = 1'b0;
        for (int b = 1; b < `BLOCK_LOCKS - 1; b++)
        begin
            if (block_locks[b] && cmd_hi[20:16] >= 5'(b) && cmd_lo[20:16] <= 5'(b))
                lock_hit = 1'b1;                                           // [RL18]
        end
        for (int s = 0; s < `SECTOR_LOCKS; s++)
        begin
            if (sector_locks[s]
                && ({s[4], s[4], s[4], s[4], s[4], s[3:0]} >= cmd_lo[20:12])
                && ({s[4], s[4], s[4], s[4], s[4], s[3:0]} <= cmd_hi[20:12]))
                lock_hit = 1'b1;                                           // [RL18]
        end
        next_allowed = protect_scheme_select ? !lock_hit : !pd.hit;        // [RL8] [RL17] [RL19]
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_done    <= 1'b0;
            cmd_allowed <= 1'b0;
        end
        else
        begin
            cmd_done <= cmd_valid;
            if (cmd_valid)
                cmd_allowed <= next_allowed;                               // [RL17]
        end
    end

    // Registered views; reserved bits read as zero
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_config_one   <= `SR1_RESET;
            status_config_two   <= `SR2_RESET;
            status_config_three <= `SR3_RESET;
            write_guard_active  <= 1'b1;
            pause_pin_active    <= 1'b1;
            quad_io_active      <= 1'b0;
            drive_percent       <= `DRIVE_QUARTER;
        end
        else
        begin
            status_config_one   <= {1'b0, range_fields, 2'b00};            // [RL11]
            status_config_two   <= {paused_op_flag, invert_protect, otp_area_locks,
                                    1'b0, quad_enable, 1'b0};
            status_config_three <= {1'b0, output_strength, 2'b00, protect_scheme_select, 2'b00};
            write_guard_active  <= !quad_enable;                           // [RL5]
            pause_pin_active    <= !quad_enable;
            quad_io_active      <= quad_enable;                            // [RL6]
            drive_percent       <= drive_decode(output_strength);          // [RL10]
        end
    end
endmodule

// File: status_asserts.sv
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module status_checker
(
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       exec_valid,
    input wire logic [7:0] exec_opcode,
    input wire logic       wr_two,
    input wire logic       wr_three,
    input wire logic [7:0] wr_data,
    input wire logic       cmd_valid,
    input wire logic [7:0] status_config_two,
    input wire logic       write_guard_active,
    input wire logic       pause_pin_active,
    input wire logic       quad_io_active,
    input wire logic [6:0] drive_percent,
    input wire logic       cmd_done,
    input wire logic       cmd_allowed
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    AST_PINS: assert property (
        write_guard_active == !quad_io_active && pause_pin_active == write_guard_active)
        else $error("pin roles disagree with quad mode");
    AST_QUAD: assert property (
        wr_two |-> ##2 quad_io_active == $past(wr_data[1], 2))
        else $error("quad mode does not follow write");
    AST_DRIVE: assert property (
        wr_three |-> ##2 drive_percent == 7'd100 - 7'd25 * 7'($past(wr_data[6:5], 2)))
        else $error("drive strength decode wrong");
    AST_DONE: assert property (
        cmd_valid |=> cmd_done)
        else $error("no answer one cycle after check request");
    AST_DONE_IDLE: assert property (
        !cmd_valid |=> !cmd_done)
        else $error("answer without request");
    AST_HOLD: assert property (
        !cmd_done |-> $stable(cmd_allowed))
        else $error("verdict changed between answers");
    AST_PAUSE_SET: assert property (
        exec_valid && exec_opcode == `OPC_SUSPEND |-> ##2 status_config_two[7])
        else $error("paused flag not set by suspend");
    AST_PAUSE_CLR: assert property (
        exec_valid && exec_opcode == `OPC_RESUME |-> ##2 !status_config_two[7])
        else $error("paused flag not cleared by resume");
    AST_OTP: assert property (
        ($past(status_config_two[5:3]) & ~status_config_two[5:3]) == 3'b000)
        else $error("security lock bit cleared");
endmodule

bind flash_status_protect_decode status_checker i_status_checker
(
    .clk_sys(clk_sys), .arst_n(arst_n), .exec_valid(exec_valid), .exec_opcode(exec_opcode),
    .wr_two(wr_two), .wr_three(wr_three), .wr_data(wr_data), .cmd_valid(cmd_valid),
    .status_config_two(status_config_two), .write_guard_active(write_guard_active),
    .pause_pin_active(pause_pin_active), .quad_io_active(quad_io_active),
    .drive_percent(drive_percent), .cmd_done(cmd_done), .cmd_allowed(cmd_allowed)
);

// File: host_model.sv
`timescale 1ns/1ps
module host_model
(
    input  wire logic        clk_sys,
    input  wire logic        cmd_done,
    input  wire logic        cmd_allowed,
    output logic             power_cycle,
    output logic             exec_valid,
    output logic [7:0]       exec_opcode,
    output logic             wr_one,
    output logic             wr_two,
    output logic             wr_three,
    output logic [7:0]       wr_data,
    output logic             lock_set,
    output logic             lock_clear,
    output logic [20:0]      lock_addr,
    output logic             cmd_valid,
    output logic [20:0]      cmd_addr,
    output logic [2:0]       cmd_size
);
    initial
    begin
        {power_cycle, exec_valid, wr_one, wr_two, wr_three, lock_set, lock_clear, cmd_valid} = 8'h00;
        {exec_opcode, wr_data} = 16'h0000;
        {lock_addr, cmd_addr, cmd_size} = 45'h0;
    end

    // Released lines show the inverse so stale data is never mistaken for valid
    task automatic wr(input int r, input logic [7:0] d);
        @(posedge clk_sys);
        wr_one <= r == 1;
        wr_two <= r == 2;
        wr_three <= r == 3;
        wr_data <= d & (r == 1 ? 8'h7C : r == 2 ? 8'h7A : 8'h64);
        @(posedge clk_sys);
        {wr_one, wr_two, wr_three} <= 3'b000;
        wr_data <= ~wr_data;
        repeat (2) @(posedge clk_sys);
    endtask

    // Kind 0 instruction, 1 power cycle, 2 lock set, 3 lock clear
    task automatic pulse(input int k, input logic [7:0] op, input logic [20:0] a);
        @(posedge clk_sys);
        exec_valid <= k == 0;
        power_cycle <= k == 1;
        lock_set <= k == 2;
        lock_clear <= k == 3;
        exec_opcode <= op;
        lock_addr <= a;
        @(posedge clk_sys);
        {exec_valid, power_cycle, lock_set, lock_clear} <= 4'h0;
        exec_opcode <= ~op;
        lock_addr <= ~a;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic cmd(input logic [20:0] a, input logic [2:0] s, output logic ok);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_addr <= a;
        cmd_size <= s;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_addr <= ~a;
        // Verdict is taken at the edge that sees the answer standing
        @(posedge clk_sys);
        ok = cmd_done === 1'b1 ? cmd_allowed : 1'bx;
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk_sys, arst_n, ok;
    logic        power_cycle, exec_valid, wr_one, wr_two, wr_three, lock_set, lock_clear, cmd_valid;
    logic [7:0]  exec_opcode, wr_data, status_config_one, status_config_two, status_config_three;
    logic [20:0] lock_addr, cmd_addr;
    logic [2:0]  cmd_size;
    logic        write_guard_active, pause_pin_active, quad_io_active, cmd_done, cmd_allowed;
    logic [6:0]  drive_percent;
    int          failures;
    int          total_checks;

    flash_status_protect_decode i_flash_status_protect_decode
    (
        .clk_sys(clk_sys), .arst_n(arst_n), .power_cycle(power_cycle), .exec_valid(exec_valid),
        .exec_opcode(exec_opcode), .wr_one(wr_one), .wr_two(wr_two), .wr_three(wr_three), .wr_data(wr_data),
        .lock_set(lock_set), .lock_clear(lock_clear), .lock_addr(lock_addr), .cmd_valid(cmd_valid),
        .cmd_addr(cmd_addr), .cmd_size(flash_status_pkg::cmd_size_t'(cmd_size)),
        .status_config_one(status_config_one), .status_config_two(status_config_two),
        .status_config_three(status_config_three), .write_guard_active(write_guard_active),
        .pause_pin_active(pause_pin_active), .quad_io_active(quad_io_active),
        .drive_percent(drive_percent), .cmd_done(cmd_done), .cmd_allowed(cmd_allowed)
    );

    host_model i_host_model
    (
        .clk_sys(clk_sys), .cmd_done(cmd_done), .cmd_allowed(cmd_allowed), .power_cycle(power_cycle),
        .exec_valid(exec_valid), .exec_opcode(exec_opcode), .wr_one(wr_one), .wr_two(wr_two),
        .wr_three(wr_three), .wr_data(wr_data), .lock_set(lock_set), .lock_clear(lock_clear),
        .lock_addr(lock_addr), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_size(cmd_size)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Set the protect fields, then ask about one erase or program
    task automatic prot(input logic [7:0] one, input logic [7:0] two, input logic [20:0] a,
                        input logic [2:0] s, input logic exp);
        i_host_model.wr(1, one);
        i_host_model.wr(2, two);
        i_host_model.cmd(a, s, ok);
        chk({7'h00, ok}, {7'h00, exp});
    endtask

    // The run needs about 350 cycles; 4000 leaves room without hiding a hang
    initial
    begin
        #100us;
        failures++;
        summarize;
    end

    initial
    begin
        failures = 0;
        total_checks = 0;
        arst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1;
        chk(status_config_two, 8'h00);
        chk(status_config_three, 8'h60);
        chk({5'h00, write_guard_active, pause_pin_active, quad_io_active}, 8'h06);
        for (int i = 0; i < 4; i++)
        begin
            i_host_model.wr(3, 8'(i << 5));
            chk({1'b0, drive_percent}, 8'(100 - 25 * i));
        end
        i_host_model.wr(2, 8'h02);
        chk({5'h00, write_guard_active, pause_pin_active, quad_io_active}, 8'h01);
        i_host_model.wr(2, 8'h00);
        chk({5'h00, write_guard_active, pause_pin_active, quad_io_active}, 8'h06);
        i_host_model.pulse(0, 8'h75, 21'h0);
        chk(status_config_two, 8'h80);
        i_host_model.pulse(0, 8'h7A, 21'h0);
        chk(status_config_two, 8'h00);
        i_host_model.pulse(0, 8'h75, 21'h0);
        i_host_model.pulse(1, 8'h00, 21'h0);
        chk(status_config_two, 8'h00);
        i_host_model.wr(2, 8'h08);
        chk(status_config_two, 8'h08);
        i_host_model.wr(2, 8'h30);
        chk(status_config_two, 8'h38);
        i_host_model.wr(1, 8'hFF);
        chk(status_config_one, 8'h7C);
        prot(8'h04, 8'h00, 21'h1F0000, 3'h1, 1'b0);
        prot(8'h04, 8'h00, 21'h1EF000, 3'h1, 1'b1);
        prot(8'h34, 8'h00, 21'h0FF000, 3'h1, 1'b0);
        prot(8'h34, 8'h00, 21'h100000, 3'h1, 1'b1);
        prot(8'h44, 8'h00, 21'h1FF000, 3'h0, 1'b0);
        prot(8'h44, 8'h00, 21'h1FE000, 3'h1, 1'b1);
        prot(8'h74, 8'h00, 21'h007000, 3'h1, 1'b0);
        prot(8'h74, 8'h00, 21'h008000, 3'h1, 1'b1);
        prot(8'h58, 8'h00, 21'h000000, 3'h0, 1'b0);
        prot(8'h1C, 8'h00, 21'h0F0000, 3'h3, 1'b0);
        prot(8'h00, 8'h00, 21'h000000, 3'h4, 1'b1);
        prot(8'h00, 8'h40, 21'h100000, 3'h0, 1'b0);
        prot(8'h04, 8'h40, 21'h1F0000, 3'h3, 1'b1);
        prot(8'h04, 8'h40, 21'h1EFF00, 3'h0, 1'b0);
        prot(8'h18, 8'h40, 21'h000000, 3'h4, 1'b1);
        prot(8'h44, 8'h00, 21'h1F0000, 3'h3, 1'b0);
        prot(8'h44, 8'h00, 21'h1F0000, 3'h2, 1'b1);
        prot(8'h44, 8'h00, 21'h000000, 3'h4, 1'b0);
        i_host_model.wr(3, 8'h64);
        chk(status_config_three, 8'h64);
        prot(8'h00, 8'h00, 21'h100000, 3'h3, 1'b0);
        i_host_model.pulse(3, 8'h00, 21'h100000);
        prot(8'h1C, 8'h00, 21'h10ABCD, 3'h0, 1'b1);
        prot(8'h1C, 8'h00, 21'h110000, 3'h0, 1'b0);
        i_host_model.pulse(3, 8'h00, 21'h1FF000);
        prot(8'h00, 8'h00, 21'h1FF000, 3'h1, 1'b1);
        prot(8'h00, 8'h00, 21'h1FE000, 3'h1, 1'b0);
        i_host_model.pulse(2, 8'h00, 21'h100000);
        prot(8'h00, 8'h00, 21'h100000, 3'h3, 1'b0);
        i_host_model.pulse(1, 8'h00, 21'h0);
        prot(8'h00, 8'h00, 21'h1FF000, 3'h1, 1'b0);
        summarize;
    end
endmodule
